// [design/pci_device_end.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pci_target_cfg.svh"
module pci_device_end
  import pci_target_pkg::*;
#(
  parameter int WAIT_CYCLES = `WAIT_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  pci_bus_if.device        bus,
  input  wire logic [31:0] user_rd_data,
  input  wire logic [7:1]  user_events,
  output logic [31:0]      user_addr,
  output logic [31:0]      user_wdata,
  output logic [3:0]       user_be_n,
  output logic             user_wr,
  output logic             user_rd
);
  target_state_t state_reg, state_next;
  bus_cmd_t      cmd_reg, cmd_next;
  logic [31:0]   addr_reg, addr_next, ad_reg, ad_next, base_reg, base_next;
  logic [31:0]   wdata_next, read_word, addr_step;
  logic [7:0]    mask_reg, mask_next, status_reg, status_next, clear_bits;
  logic [3:0]    wait_reg, wait_next, be_next;
  logic          ad_oe_reg, ad_oe_next, par_reg, par_oe_reg, ctl_oe_reg, ctl_oe_next;
  logic          trdy_reg, trdy_next, stop_reg, stop_next, devsel_reg, devsel_next;
  logic          chk_reg, chk_next, exp_reg, exp_next, inta_reg, perr_event;
  logic          wr_next, rd_next, in_par, out_par, hit, last_word;

  even_parity #(.WIDTH(36)) in_gen (.bits({bus.ad, bus.cbe_n}), .parity(in_par));
  even_parity #(.WIDTH(36)) out_gen (.bits({ad_reg, bus.cbe_n}), .parity(out_par));

  // Register reads: configuration words, the two interrupt registers, or user data.
  always_comb
  begin
    read_word = user_rd_data;
    if (cmd_is_cfg(cmd_reg))
    begin
      read_word = 32'h0000_0000;
      if (addr_reg[7:0] == `CFG_ID_OFFSET)
        read_word = `CFG_ID_VALUE;
      else if (addr_reg[7:0] == `CFG_BASE_OFFSET)
        read_word = base_reg;
    end
    else if (addr_reg[4:0] == `STATUS_OFFSET)
      read_word = {24'h00_0000, status_reg}; // RULE16
    else if (addr_reg[4:0] == `MASK_OFFSET)
      read_word = {24'h00_0000, mask_reg};
  end

  // A window access decodes only once software has placed the base word.
  assign hit = cmd_is_cfg(bus_cmd_t'(bus.cbe_n))
             ? (bus.idsel && (bus.ad[1:0] == 2'b00)) // RULE13
             : (cmd_is_window(bus_cmd_t'(bus.cbe_n)) && (base_reg != `RESET_BASE) &&
                ((bus.ad & `WINDOW_MASK) == base_reg)); // RULE14
  assign addr_step = addr_reg + `WINDOW_STEP;
  // Configuration cycles carry one word only; a burst stops at the window end.
  assign last_word = cmd_is_cfg(cmd_reg) || ((addr_step & `WINDOW_MASK) != base_reg);
  // Address and write data are checked the clock after they stood on the bus.
  assign perr_event = chk_reg && (bus.par != exp_reg); // RULE5

  // Target sequencing: decode, wait states, transfers, stop and turnaround.
  always_comb
  begin
    state_next  = state_reg;
    cmd_next    = cmd_reg;
    addr_next   = addr_reg;
    ad_next     = ad_reg;
    ad_oe_next  = ad_oe_reg;
    ctl_oe_next = ctl_oe_reg;
    trdy_next   = trdy_reg;
    stop_next   = stop_reg;
    devsel_next = devsel_reg;
    wait_next   = wait_reg;
    base_next   = base_reg;
    mask_next   = mask_reg;
    clear_bits  = 8'h00;
    chk_next    = 1'b0;
    exp_next    = exp_reg;
    wr_next     = 1'b0;
    rd_next     = 1'b0;
    wdata_next  = user_wdata;
    be_next     = user_be_n;
    unique case (state_reg)
      T_IDLE:
      begin
        // The first clock with frame low is the address phase.
        if (!bus.frame_n) // RULE18
        begin
          cmd_next  = bus_cmd_t'(bus.cbe_n); // RULE1
          addr_next = bus.ad;
          if (hit)
          begin
            chk_next    = 1'b1;
            exp_next    = in_par; // RULE3
            devsel_next = 1'b0; // RULE14
            ctl_oe_next = 1'b1;
            wait_next   = 4'(WAIT_CYCLES);
            state_next  = T_XFER;
          end
          else
            state_next = T_SKIP;
        end
      end
      T_XFER:
      begin
        if (!trdy_reg && !bus.irdy_n) // RULE9
        begin
          trdy_next = 1'b1;
          addr_next = addr_step;
          wait_next = 4'(WAIT_CYCLES);
          if (cmd_is_read(cmd_reg))
            rd_next = 1'b1;
          else
          begin
            chk_next = 1'b1;
            exp_next = in_par; // RULE6
            // Cleared lanes are only those whose byte enable is low.
            if (cmd_is_cfg(cmd_reg))
            begin
              if (addr_reg[7:0] == `CFG_BASE_OFFSET)
              begin
                for (int i = 0; i < 4; i++)
                  if (!bus.cbe_n[i]) // RULE2
                    base_next[8*i +: 8] = bus.ad[8*i +: 8];
                base_next = base_next & `WINDOW_MASK;
              end
            end
            else if (addr_reg[4:0] == `STATUS_OFFSET)
            begin
              if (!bus.cbe_n[0])
                clear_bits = bus.ad[7:0]; // RULE16
            end
            else if (addr_reg[4:0] == `MASK_OFFSET)
            begin
              if (!bus.cbe_n[0])
                mask_next = bus.ad[7:0]; // RULE15
            end
            else
            begin
              wr_next    = 1'b1;
              wdata_next = bus.ad;
              be_next    = bus.cbe_n; // RULE2
            end
          end
          if (bus.frame_n)
          begin
            devsel_next = 1'b1;
            ad_oe_next  = 1'b0;
            state_next  = T_TURN;
          end
          else if (last_word)
          begin
            stop_next  = 1'b0; // RULE12
            ad_oe_next = 1'b0;
            state_next = T_HALT;
          end
        end
        else if (trdy_reg)
        begin
          if (wait_reg != 4'h0)
            wait_next = wait_reg - 4'h1;
          else
          begin
            // Read data is loaded on the very edge that asserts target-ready.
            trdy_next = 1'b0; // RULE11
            if (cmd_is_read(cmd_reg))
            begin
              ad_next    = read_word;
              ad_oe_next = 1'b1;
            end
          end
        end
      end
      T_HALT:
      begin
        // Stop stands until the master has released frame.
        if (bus.frame_n && !bus.irdy_n) // RULE12
        begin
          stop_next   = 1'b1;
          devsel_next = 1'b1;
          state_next  = T_TURN;
        end
      end
      T_TURN:
      begin
        // Controls were driven high for one clock; now let them float.
        ctl_oe_next = 1'b0;
        state_next  = T_IDLE;
      end
      T_SKIP:
      begin
        if (bus.frame_n && bus.irdy_n)
          state_next = T_IDLE;
      end
      default:
      begin
        state_next = T_IDLE;
      end
    endcase
    // Hardware setting wins over a clear in the same cycle.
    status_next = (status_reg & ~clear_bits) | {user_events, perr_event}; // RULE16
  end

  // Registers of the device end; parity follows the driven data by one clock.
  always_ff @(posedge clock or posedge reset) // RULE17
  begin
    if (reset)
    begin
      state_reg  <= T_IDLE;
      cmd_reg    <= CMD_INT_ACK;
      addr_reg   <= 32'h0000_0000;
      ad_reg     <= 32'h0000_0000;
      ad_oe_reg  <= 1'b0;
      par_reg    <= 1'b0;
      par_oe_reg <= 1'b0;
      ctl_oe_reg <= 1'b0;
      trdy_reg   <= 1'b1;
      stop_reg   <= 1'b1;
      devsel_reg <= 1'b1;
      wait_reg   <= 4'h0;
      base_reg   <= `RESET_BASE;
      mask_reg   <= `RESET_MASK;
      status_reg <= `RESET_STATUS;
      chk_reg    <= 1'b0;
      exp_reg    <= 1'b0;
      inta_reg   <= 1'b0;
      user_addr  <= 32'h0000_0000;
      user_wdata <= 32'h0000_0000;
      user_be_n  <= 4'hf;
      user_wr    <= 1'b0;
      user_rd    <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      cmd_reg    <= cmd_next;
      addr_reg   <= addr_next;
      ad_reg     <= ad_next;
      ad_oe_reg  <= ad_oe_next;
      par_reg    <= out_par; // RULE6
      par_oe_reg <= ad_oe_reg; // RULE4 RULE7
      ctl_oe_reg <= ctl_oe_next;
      trdy_reg   <= trdy_next;
      stop_reg   <= stop_next;
      devsel_reg <= devsel_next;
      wait_reg   <= wait_next;
      base_reg   <= base_next;
      mask_reg   <= mask_next;
      status_reg <= status_next;
      chk_reg    <= chk_next;
      exp_reg    <= exp_next;
      inta_reg   <= |(status_reg & mask_reg); // RULE15 RULE19
      user_addr  <= (wr_next || rd_next) ? addr_reg : addr_next; // Pulse keeps its own address.
      user_wdata <= wdata_next;
      user_be_n  <= be_next;
      user_wr    <= wr_next;
      user_rd    <= rd_next;
    end
  end

  assign bus.dev_ad_o       = ad_reg;
  assign bus.dev_ad_oe      = ad_oe_reg;
  assign bus.dev_par_o      = par_reg;
  assign bus.dev_par_oe     = par_oe_reg;
  assign bus.dev_trdy_n_o   = trdy_reg;
  assign bus.dev_stop_n_o   = stop_reg;
  assign bus.dev_devsel_n_o = devsel_reg;
  assign bus.dev_ctl_oe     = ctl_oe_reg;
  assign bus.dev_inta_oe    = inta_reg; // RULE15
endmodule // pci_device_end
`default_nettype wire

// [design/pci_target_cfg.svh]
`ifndef PCI_TARGET_CFG_SVH
`define PCI_TARGET_CFG_SVH
// What this block does
// RULE1: Address phase command lines carry one of 16 commands.
// RULE2: Data phase byte enable n marks byte lane n.
// RULE3: Parity is even over address/data and command lines.
// RULE4: Device drives read parity; host drives address, write.
// RULE5: Host gives address parity one clock after address.
// RULE6: Data parity valid one clock after ready assertion.
// RULE7: Parity driver holds it one clock past completion.
// RULE8: Host frame starts transaction; release marks final phase.
// RULE9: Data phase completes only with both readies asserted.
// RULE10: Host asserts initiator-ready only with data or space.
// RULE11: Device asserts target-ready only with data or space.
// RULE12: Device asserts stop to end the transaction.
// RULE13: Configuration cycles answered only with its select asserted.
// RULE14: Device-select asserted only after its address decodes.
// RULE15: Open-drain interrupt request, gated by the mask register.
// RULE16: Interrupt status register records cause, readable by host.
// RULE17: Everything on rising clock edge; reset is asynchronous.
// RULE18: Address phase is first clock with frame asserted.
// RULE19: Interrupt held low while any unmasked status bit set.

// Configuration space offsets; other configuration words read as zero.
`define CFG_ID_OFFSET     8'h00
`define CFG_BASE_OFFSET   8'h10
// Identity word; the value is arbitrary.
`define CFG_ID_VALUE      32'h5a5a_0001
// Address window decoded from the base word: 32 bytes.
`define WINDOW_MASK       32'hffff_ffe0
`define WINDOW_STEP       32'h0000_0004
// Word offsets of the interrupt registers inside the window.
`define STATUS_OFFSET     5'h00
`define MASK_OFFSET       5'h04
// Status bit set by the device itself on a parity mismatch.
`define PERR_BIT          0
`define RESET_BASE        32'h0000_0000
`define RESET_MASK        8'h00
`define RESET_STATUS      8'h00
`define WAIT_CYCLES       2
`define ABORT_CYCLES      5
`endif

// [design/pci_target_pkg.sv]
package pci_target_pkg;

  // Bus command codes on the command/byte-enable lines.
  typedef enum logic [3:0] {
    CMD_INT_ACK    = 4'h0,
    CMD_SPECIAL    = 4'h1,
    CMD_IO_READ    = 4'h2,
    CMD_IO_WRITE   = 4'h3,
    CMD_RSVD_4     = 4'h4,
    CMD_RSVD_5     = 4'h5,
    CMD_MEM_READ   = 4'h6,
    CMD_MEM_WRITE  = 4'h7,
    CMD_RSVD_8     = 4'h8,
    CMD_RSVD_9     = 4'h9,
    CMD_CFG_READ   = 4'ha,
    CMD_CFG_WRITE  = 4'hb,
    CMD_MEM_RD_MUL = 4'hc,
    CMD_DUAL_ADDR  = 4'hd,
    CMD_MEM_RD_LN  = 4'he,
    CMD_MEM_WR_INV = 4'hf
  } bus_cmd_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_XFER = 3'b001,
    T_HALT = 3'b010,
    T_TURN = 3'b011,
    T_SKIP = 3'b100
  } target_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ADDR = 2'b01,
    H_DATA = 2'b10,
    H_END  = 2'b11
  } host_state_t;

  // Reads are the even codes of the command set.
  function automatic logic cmd_is_read(input bus_cmd_t cmd);
    return ~cmd[0];
  endfunction

  function automatic logic cmd_is_cfg(input bus_cmd_t cmd);
    return (cmd == CMD_CFG_READ) || (cmd == CMD_CFG_WRITE);
  endfunction

  // Plain reads and writes in I/O or memory space reach the window.
  function automatic logic cmd_is_window(input bus_cmd_t cmd);
    return (cmd == CMD_IO_READ) || (cmd == CMD_IO_WRITE) ||
           (cmd == CMD_MEM_READ) || (cmd == CMD_MEM_WRITE);
  endfunction

endpackage

// [design/pci_bus_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface pci_bus_if;
  // Resolved wire levels.
  logic [31:0] ad;
  logic [3:0]  cbe_n;
  logic        par;
  logic        frame_n;
  logic        irdy_n;
  logic        trdy_n;
  logic        stop_n;
  logic        devsel_n;
  logic        idsel;
  logic        inta_n;
  // Host drive.
  logic [31:0] host_ad_o;
  logic        host_ad_oe;
  logic [3:0]  host_cbe_n_o;
  logic        host_par_o;
  logic        host_par_oe;
  logic        host_frame_n_o;
  logic        host_irdy_n_o;
  logic        host_idsel_o;
  // Device drive.
  logic [31:0] dev_ad_o;
  logic        dev_ad_oe;
  logic        dev_par_o;
  logic        dev_par_oe;
  logic        dev_trdy_n_o;
  logic        dev_stop_n_o;
  logic        dev_devsel_n_o;
  logic        dev_ctl_oe;
  logic        dev_inta_oe;

  // Undriven control lines float high through the pull-ups.
  assign ad       = dev_ad_oe ? dev_ad_o : (host_ad_oe ? host_ad_o : 32'h0000_0000);
  assign cbe_n    = host_cbe_n_o;
  assign par      = dev_par_oe ? dev_par_o : (host_par_oe ? host_par_o : 1'b0);
  assign frame_n  = host_frame_n_o;
  assign irdy_n   = host_irdy_n_o;
  assign idsel    = host_idsel_o;
  assign trdy_n   = dev_ctl_oe ? dev_trdy_n_o : 1'b1;
  assign stop_n   = dev_ctl_oe ? dev_stop_n_o : 1'b1;
  assign devsel_n = dev_ctl_oe ? dev_devsel_n_o : 1'b1;
  assign inta_n   = ~dev_inta_oe;

  modport device (
    input  ad, cbe_n, par, frame_n, irdy_n, idsel,
    output dev_ad_o, dev_ad_oe, dev_par_o, dev_par_oe, dev_trdy_n_o,
    output dev_stop_n_o, dev_devsel_n_o, dev_ctl_oe, dev_inta_oe
  );

  modport host (
    input  ad, par, trdy_n, stop_n, devsel_n, inta_n,
    output host_ad_o, host_ad_oe, host_cbe_n_o, host_par_o, host_par_oe,
    output host_frame_n_o, host_irdy_n_o, host_idsel_o
  );
endinterface // pci_bus_if
`default_nettype wire

// [design/even_parity.sv]
`timescale 1ns/1ns
`default_nettype none
module even_parity #(
  parameter int WIDTH = 36
) (
  input  wire logic [WIDTH-1:0] bits,
  output logic                  parity
);
  // The parity bit makes the count of ones over bits plus parity even.
  assign parity = ^bits; // RULE3
endmodule // even_parity
`default_nettype wire

// [design/pci_host_end.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pci_target_cfg.svh"
module pci_host_end
  import pci_target_pkg::*;
#(
  parameter int ABORT_CYCLES = `ABORT_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  pci_bus_if.host          bus,
  input  wire logic        req,
  input  wire bus_cmd_t    req_cmd,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  input  wire logic [3:0]  req_be_n,
  input  wire logic        req_cfg,
  output logic             busy,
  output logic             done,
  output logic [31:0]      rdata,
  output logic             aborted,
  output logic             stopped,
  output logic             perr
);
  host_state_t state_reg, state_next;
  bus_cmd_t    cmd_reg, cmd_next;
  logic [31:0] ad_reg, ad_next, rdata_next;
  logic [3:0]  cbe_reg, cbe_next;
  logic [3:0]  count_reg, count_next;
  logic        ad_oe_reg, ad_oe_next, par_reg, par_next, par_oe_reg, par_oe_next;
  logic        frame_reg, frame_next, irdy_reg, irdy_next, idsel_reg, idsel_next;
  logic        busy_next, done_next, abort_next, stop_next, perr_next;
  logic        exp_reg, exp_next, out_par, in_par;

  even_parity #(.WIDTH(36)) out_gen (.bits({ad_reg, cbe_reg}), .parity(out_par));
  even_parity #(.WIDTH(36)) in_gen (.bits({bus.ad, cbe_reg}), .parity(in_par));

  // One transaction per request, always a single data phase, so frame is
  // released together with the first initiator-ready.
  always_comb
  begin
    state_next  = state_reg;
    cmd_next    = cmd_reg;
    ad_next     = ad_reg;
    ad_oe_next  = ad_oe_reg;
    cbe_next    = cbe_reg;
    count_next  = count_reg;
    par_next    = par_reg;
    par_oe_next = par_oe_reg;
    frame_next  = frame_reg;
    irdy_next   = irdy_reg;
    idsel_next  = idsel_reg;
    exp_next    = exp_reg;
    rdata_next  = rdata;
    busy_next   = busy;
    done_next   = 1'b0;
    abort_next  = aborted;
    stop_next   = stopped;
    perr_next   = perr;
    unique case (state_reg)
      H_IDLE:
      begin
        if (req)
        begin
          frame_next = 1'b0; // RULE8
          ad_next    = req_addr;
          ad_oe_next = 1'b1;
          cbe_next   = req_cmd; // RULE1
          cmd_next   = req_cmd;
          idsel_next = req_cfg;
          busy_next  = 1'b1;
          abort_next = 1'b0;
          stop_next  = 1'b0;
          perr_next  = 1'b0;
          state_next = H_ADDR;
        end
      end
      H_ADDR:
      begin
        frame_next  = 1'b1; // RULE8
        irdy_next   = 1'b0; // RULE10
        cbe_next    = req_be_n; // RULE2
        idsel_next  = 1'b0;
        par_next    = out_par; // RULE5
        par_oe_next = 1'b1; // RULE4
        count_next  = 4'h0;
        if (cmd_is_read(cmd_reg))
          ad_oe_next = 1'b0;
        else
          ad_next = req_wdata; // RULE10
        state_next = H_DATA;
      end
      H_DATA:
      begin
        par_next    = out_par; // RULE6
        par_oe_next = ~cmd_is_read(cmd_reg); // RULE4
        count_next  = count_reg + 4'h1;
        if (!bus.devsel_n && !bus.trdy_n)
        begin
          rdata_next = bus.ad; // RULE9
          exp_next   = in_par;
          irdy_next  = 1'b1;
          state_next = H_END;
        end
        else if (!bus.stop_n)
        begin
          stop_next  = 1'b1;
          irdy_next  = 1'b1;
          state_next = H_END;
        end
        else if (bus.devsel_n && (count_reg == 4'(ABORT_CYCLES)))
        begin
          abort_next = 1'b1;
          irdy_next  = 1'b1;
          state_next = H_END;
        end
      end
      H_END:
      begin
        // Write parity stood through this cycle; the read parity arrives now.
        ad_oe_next  = 1'b0;
        par_oe_next = 1'b0; // RULE7
        if (cmd_is_read(cmd_reg) && !aborted && !stopped)
          perr_next = (bus.par != exp_reg); // RULE3
        busy_next  = 1'b0;
        done_next  = 1'b1;
        state_next = H_IDLE;
      end
    endcase
  end

  // Registers of the host end.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_reg  <= H_IDLE;
      cmd_reg    <= CMD_INT_ACK;
      ad_reg     <= 32'h0000_0000;
      ad_oe_reg  <= 1'b0;
      cbe_reg    <= 4'hf;
      count_reg  <= 4'h0;
      par_reg    <= 1'b0;
      par_oe_reg <= 1'b0;
      frame_reg  <= 1'b1;
      irdy_reg   <= 1'b1;
      idsel_reg  <= 1'b0;
      exp_reg    <= 1'b0;
      rdata      <= 32'h0000_0000;
      busy       <= 1'b0;
      done       <= 1'b0;
      aborted    <= 1'b0;
      stopped    <= 1'b0;
      perr       <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      cmd_reg    <= cmd_next;
      ad_reg     <= ad_next;
      ad_oe_reg  <= ad_oe_next;
      cbe_reg    <= cbe_next;
      count_reg  <= count_next;
      par_reg    <= par_next;
      par_oe_reg <= par_oe_next;
      frame_reg  <= frame_next;
      irdy_reg   <= irdy_next;
      idsel_reg  <= idsel_next;
      exp_reg    <= exp_next;
      rdata      <= rdata_next;
      busy       <= busy_next;
      done       <= done_next;
      aborted    <= abort_next;
      stopped    <= stop_next;
      perr       <= perr_next;
    end
  end

  assign bus.host_ad_o      = ad_reg;
  assign bus.host_ad_oe     = ad_oe_reg;
  assign bus.host_cbe_n_o   = cbe_reg;
  assign bus.host_par_o     = par_reg;
  assign bus.host_par_oe    = par_oe_reg;
  assign bus.host_frame_n_o = frame_reg;
  assign bus.host_irdy_n_o  = irdy_reg;
  assign bus.host_idsel_o   = idsel_reg;
endmodule // pci_host_end
`default_nettype wire

// [bench/pci_target_interface_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module pci_target_interface_sva #(
  parameter int WAIT_CYCLES = 2
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe_n,
  input wire logic        par,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic        trdy_n,
  input wire logic        stop_n,
  input wire logic        devsel_n,
  input wire logic        idsel,
  input wire logic        inta_n,
  input wire logic        dev_ad_oe,
  input wire logic        dev_par_oe
);
  localparam int LAG = WAIT_CYCLES + 1;
  logic rd_reg;
  logic rd_next;
  logic frame_n_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Direction is latched at the address phase, since the command is gone after it.
  assign rd_next = (!frame_n && frame_n_reg) ? !cbe_n[0] : rd_reg;
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rd_reg      <= 1'b0;
      frame_n_reg <= 1'b1;
    end
    else
    begin
      rd_reg      <= rd_next;
      frame_n_reg <= frame_n;
    end
  end
  // Parity covers the bus and command lines one clock late.
  property p_addr_par;
    $fell(frame_n) |=> par == ^{$past(ad), $past(cbe_n)};
  endproperty
  a_addr_par: assert property (p_addr_par)
    else $error("address parity wrong");
  property p_data_par;
    (!irdy_n && !trdy_n) |=> par == ^{$past(ad), $past(cbe_n)};
  endproperty
  a_data_par: assert property (p_data_par)
    else $error("data parity wrong after completion");
  property p_rd_par_dev;
    (!trdy_n && rd_reg) |=> dev_par_oe;
  endproperty
  a_rd_par_dev: assert property (p_rd_par_dev)
    else $error("device not driving read parity");
  property p_rd_trdy_data;
    (!trdy_n && rd_reg) |-> dev_ad_oe;
  endproperty
  a_rd_trdy_data: assert property (p_rd_trdy_data)
    else $error("read ready without data driven");
  property p_trdy_hold;
    (!trdy_n && irdy_n) |=> !trdy_n;
  endproperty
  a_trdy_hold: assert property (p_trdy_hold)
    else $error("target ready dropped before completion");
  property p_trdy_lag;
    $fell(devsel_n) |-> trdy_n [*3] ##(LAG - 2) !trdy_n;
  endproperty
  a_trdy_lag: assert property (p_trdy_lag)
    else $error("target ready at wrong cycle");
  property p_devsel_decode;
    $fell(devsel_n) |-> $past(frame_n) == 1'b0;
  endproperty
  a_devsel_decode: assert property (p_devsel_decode)
    else $error("device select without address phase");
  property p_cfg_idsel;
    ($fell(frame_n) && cbe_n[3:1] == 3'b101 && !idsel) |=> devsel_n [*4];
  endproperty
  a_cfg_idsel: assert property (p_cfg_idsel)
    else $error("configuration answered without select");
  property p_stop;
    !stop_n |-> trdy_n;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop together with target ready");
  c_read: cover property (!irdy_n && !trdy_n && rd_reg);
  c_write: cover property (!irdy_n && !trdy_n && !rd_reg);
  c_abort: cover property ($fell(frame_n) ##1 devsel_n [*4]);
  c_irq: cover property ($fell(inta_n));
endmodule // pci_target_interface_sva
`default_nettype wire

// [bench/pci_target_interface_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pci_target_cfg.svh"
module pci_target_interface_bench
  import pci_target_pkg::*;
  ;
  logic        clock, reset, req, req_cfg, busy, done, aborted, stopped, perr;
  logic        user_wr, user_rd;
  bus_cmd_t    req_cmd, c;
  logic [31:0] req_addr, req_wdata, rdata, user_rd_data, user_addr, user_wdata, d;
  logic [3:0]  req_be_n, user_be_n, b;
  logic [7:1]  user_events;
  int          fail_count, n_compared;
  pci_bus_if bus ();
  pci_host_end i_pci_host_end (.clock, .reset, .bus, .req, .req_cmd, .req_addr,
    .req_wdata, .req_be_n, .req_cfg, .busy, .done, .rdata, .aborted, .stopped, .perr);
  pci_device_end #(.WAIT_CYCLES(2)) i_pci_device_end (.clock, .reset, .bus,
    .user_rd_data, .user_events, .user_addr, .user_wdata, .user_be_n, .user_wr, .user_rd);
  pci_target_interface_sva #(.WAIT_CYCLES(2)) u_sva (.clock, .reset, .ad(bus.ad),
    .cbe_n(bus.cbe_n), .par(bus.par), .frame_n(bus.frame_n), .irdy_n(bus.irdy_n),
    .trdy_n(bus.trdy_n), .stop_n(bus.stop_n), .devsel_n(bus.devsel_n), .idsel(bus.idsel),
    .inta_n(bus.inta_n), .dev_ad_oe(bus.dev_ad_oe), .dev_par_oe(bus.dev_par_oe));
  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, input logic g);
    chk_w(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One whole transaction; the wait is bounded so a lost answer cannot hang the run.
  task automatic xfer(input bus_cmd_t cm, input logic [31:0] a, input logic [31:0] w,
                      input logic [3:0] be, input logic cf);
    int n;
    n = 0;
    req = 1'b1;
    req_cmd = cm;
    req_addr = a;
    req_wdata = w;
    req_be_n = be;
    req_cfg = cf;
    @(posedge clock);
    #2;
    req = 1'b0;
    while (done !== 1'b1 && n < 40)
    begin
      @(posedge clock);
      #2;
      n++;
    end
    chk_b("done", 1'b1, done);
    chk_b("busy", 1'b0, busy);
  endtask
  // Only plain I/O and memory reads and writes reach the window.
  function automatic logic hit(input logic [3:0] cm);
    return cm == 4'h2 || cm == 4'h3 || cm == 4'h6 || cm == 4'h7;
  endfunction
  task automatic settle();
    repeat (4) @(posedge clock);
    #2;
  endtask
  // Free-running bus clock.
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Watchdog, well past the few hundred cycles the tests need.
  initial
  begin
    #60000;
    fail_count++;
    stop_test();
  end
  // Main sequence.
  initial
  begin
    {fail_count, n_compared} = '0;
    {reset, req, req_cfg, user_events, user_rd_data} = {2'h2, 40'h0};
    req_cmd = CMD_INT_ACK;
    {req_addr, req_wdata, req_be_n} = '0;
    d = $urandom(5);
    repeat (12) @(posedge clock);
    #2;
    reset = 1'b0;
    chk_b("idle trdy", 1'b1, bus.trdy_n);
    xfer(CMD_CFG_READ, 32'h0, 32'h0, 4'h0, 1'b1);
    chk_w("cfg id", `CFG_ID_VALUE, rdata);
    xfer(CMD_CFG_READ, 32'h0, 32'h0, 4'h0, 1'b0);
    chk_b("cfg unselected", 1'b1, aborted);
    xfer(CMD_CFG_WRITE, 32'h10, 32'h1000_001f, 4'h0, 1'b1);
    xfer(CMD_CFG_READ, 32'h10, 32'h0, 4'h0, 1'b1);
    chk_w("base", 32'h1000_0000, rdata);
    xfer(CMD_MEM_READ, 32'h2000_0008, 32'h0, 4'h0, 1'b0);
    chk_b("miss", 1'b1, aborted);
    $display("test config done");
    // Every command code three times in order, with random data, at a plain window word.
    for (int i = 0; i < 48; i++)
    begin
      c = bus_cmd_t'(i[3:0]);
      d = $urandom;
      b = 4'($urandom);
      user_rd_data = $urandom;
      xfer(c, 32'h1000_0008, d, b, 1'b0);
      chk_b("aborted", !hit(c), aborted);
      chk_b("stopped", 1'b0, stopped);
      if (hit(c) && c[0])
      begin
        chk_w("wdata", d, user_wdata);
        chk_w("be", {28'h0, b}, {28'h0, user_be_n});
      end
      if (hit(c) && !c[0])
      begin
        chk_w("rdata", user_rd_data, rdata);
        chk_b("perr", 1'b0, perr);
      end
    end
    $display("test commands done");
    // The event is recorded while masked, then shows once unmasked.
    user_events[3] = 1'b1;
    @(posedge clock);
    #2;
    user_events = 7'h00;
    settle();
    chk_b("irq masked", 1'b1, bus.inta_n);
    xfer(CMD_IO_READ, 32'h1000_0000, 32'h0, 4'h0, 1'b0);
    chk_w("status", 32'h08, rdata & 32'hff);
    xfer(CMD_IO_WRITE, 32'h1000_0004, 32'h08, 4'h0, 1'b0);
    settle();
    chk_b("irq on", 1'b0, bus.inta_n);
    xfer(CMD_IO_WRITE, 32'h1000_0000, 32'h08, 4'he, 1'b0);
    settle();
    chk_b("irq off", 1'b1, bus.inta_n);
    $display("test interrupt done");
    stop_test();
  end
endmodule // pci_target_interface_bench
`default_nettype wire
